// *** rtl/aru_pkg.sv ***
// Package: word map, field positions, ranges and timing of the ratio conversion unit
package aru_pkg;
    // ------------------------------------------------------------
    // Setting memory area word indices
    // ------------------------------------------------------------
    localparam int SET_WORDS = 32;
    localparam logic [4:0] OFF_BASE_SETTING = 5'h00;
    localparam logic [4:0] OFF_HOLD_OUT1 = 5'h02;
    localparam logic [4:0] OFF_HOLD_OUT2 = 5'h03;
    localparam logic [4:0] OFF_LOOP1_RATIO_CONSTANT = 5'h0A;
    localparam logic [4:0] OFF_LOOP1_BIAS_CONSTANT = 5'h0B;
    localparam logic [4:0] OFF_LOOP2_RATIO_CONSTANT = 5'h0C;
    localparam logic [4:0] OFF_LOOP2_BIAS_CONSTANT = 5'h0D;
    localparam logic [4:0] OFF_SCALE_LO_OUT1 = 5'h13;
    localparam logic [4:0] OFF_SCALE_HI_OUT1 = 5'h14;
    localparam logic [4:0] OFF_SCALE_LO_OUT2 = 5'h15;
    localparam logic [4:0] OFF_SCALE_HI_OUT2 = 5'h16;
    // ------------------------------------------------------------
    // I/O status word area indices
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_LOOP1_RESULT = 4'h5;
    localparam logic [3:0] OFF_LOOP2_RESULT = 4'h6;
    localparam logic [3:0] OFF_SET_ERROR = 4'h9;
    // ------------------------------------------------------------
    // Base setting word fields and set error word bit
    // ------------------------------------------------------------
    localparam int BIT_RANGE_BIPOLAR0 = 0;
    localparam int BIT_LOOP1_ENABLE = 8;
    localparam int BIT_LOOP1_NEGATIVE = 9;
    localparam int BIT_LOOP2_ENABLE = 10;
    localparam int BIT_LOOP2_NEGATIVE = 11;
    localparam int BIT_SET_ERR_OUT1 = 0;
    // ------------------------------------------------------------
    // Hold selections (low byte of hold word)
    // ------------------------------------------------------------
    localparam logic [7:0] HOLD_RANGE_MIN = 8'h00;
    localparam logic [7:0] HOLD_LAST = 8'h01;
    localparam logic [7:0] HOLD_RANGE_MAX = 8'h02;
    // ------------------------------------------------------------
    // Ranges at resolution 4,000
    // ------------------------------------------------------------
    localparam logic signed [31:0] FULL_UNI = 32'sh0000_0FA0;
    localparam logic signed [31:0] FULL_BIP = 32'sh0000_07D0;
    localparam logic signed [31:0] MIN_UNI = -32'sh0000_00C8;
    localparam logic signed [31:0] MAX_UNI = 32'sh0000_1068;
    localparam logic signed [31:0] MIN_BIP = -32'sh0000_0834;
    localparam logic signed [31:0] MAX_BIP = 32'sh0000_0834;
    localparam logic signed [31:0] SCALE_LIMIT = 32'sh0000_7D00;
    localparam logic signed [31:0] RATIO_DIVISOR = 32'sh0000_0064;
    localparam logic [15:0] DISCONNECT_VALUE = 16'h0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_PS = 4000;
    localparam int RESP_4K_US = 850;
    localparam int RESP_8K_US = 420;
    localparam int RESP_4K_CYCLES = (RESP_4K_US * 1000000) / CLOCK_PERIOD_PS;
    localparam int RESP_8K_CYCLES = (RESP_8K_US * 1000000) / CLOCK_PERIOD_PS;
    localparam int LOOP_LATENCY = 2;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef logic [15:0] aru_word_t;
    typedef aru_word_t [SET_WORDS-1:0] aru_settings_t;
    typedef struct packed {
        aru_word_t [1:0] setValue;
        logic [1:0] convEnable;
        logic restartReq;
        logic adjustMode;
        logic programMode;
    } aru_host_t;
    typedef struct packed {
        aru_word_t [1:0] rawIn;
        logic [1:0] disconnected;
    } aru_adc_t;
    typedef struct packed {
        aru_word_t [1:0] inOffset;
        aru_word_t [1:0] inGain;
        aru_word_t [1:0] outOffset;
        aru_word_t [1:0] outGain;
    } aru_cal_t;
endpackage : aru_pkg

// *** rtl/aru_ratio_unit.sv ***
// Output path, scaling, setting errors and ratio/bias loops of the analog I/O unit
`timescale 1ns/10ps
// Function
// - Lower scaling limit above upper limit maps values inversely onto the range.
// - Set value beyond range raises error bit 00 or 01 of status word nine.
// - Error bit follows the condition and clears by itself when it is gone.
// - Output in error drives its configured stop-state level, not the set value.
// - Two independent loops, input 1 to output 1 and 2 to 2.
// - Positive gradient: ratio times input plus bias.
// - Negative gradient: full scale minus ratio times input plus bias.
// - Ratio constant is four BCD digits, 0.01 per count.
// - Bias constant is signed 16-bit two's complement in output units.
// - Loop enable and direction come from base word bits 08 to 11.
// - Loop response stays within 850 us at 4,000, 420 us at 8,000.
// - Loop 1 constants in words ten and eleven, loop 2 in twelve, thirteen.
// - Settings load only at power-on or restart; host restarts after edits.
// - Loop results published to status words five and six.
// - Disconnected input gives result 0000 and stop-state output.
// - Result and output saturate at the range limits.
// - Scaling is never applied to an output under ratio conversion.
// - Calibrated input maps offset point to 0000, gain point to full scale.
// - Calibrated output treats offset set value as 0000, gain as full scale.
// - Adjustment outside program mode stops the unit, holding last values.
// - Hold word low byte: 00 minimum, 01 hold last, 02 maximum.
module aru_ratio_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Setting memory area and host I/O words
    input wire aru_pkg::aru_settings_t settingArea,
    input wire aru_pkg::aru_host_t host,
    // Converter side
    input wire aru_pkg::aru_adc_t adc,
    input wire aru_pkg::aru_cal_t cal,
    output logic [1:0][15:0] dacCode,
    // Status words
    output logic [15:0] loop1Result,
    output logic [15:0] loop2Result,
    output logic [15:0] setErrorWord,
    output logic unitStopped
);
    import aru_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic signed [31:0] bcdToBin(input logic [15:0] b);
        bcdToBin = 32'(b[15:12]) * 1000 + 32'(b[11:8]) * 100 + 32'(b[7:4]) * 10
            + 32'(b[3:0]);
    endfunction : bcdToBin

    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
            input logic signed [31:0] lo, input logic signed [31:0] hi);
        sat = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : sat

    function automatic logic signed [31:0] sx(input logic [15:0] w);
        sx = 32'(signed'(w));
    endfunction : sx

    // ------------------------------------------------------------
    // Setting load at power-on and restart
    // ------------------------------------------------------------
    aru_settings_t shadow_r;
    logic loadPending_r;
    logic restartSeen_r;

    // Pending set under reset, so the first load happens after release
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            loadPending_r <= 1'b1;
            restartSeen_r <= 1'b0;
        end else begin
            restartSeen_r <= host.restartReq;
            loadPending_r <= host.restartReq && !restartSeen_r;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shadow_r <= '0;
        end else if (loadPending_r) begin
            shadow_r <= settingArea;
        end
    end

    // Adjustment outside program mode freezes outputs, results and error bits
    logic freeze;
    assign freeze = host.adjustMode && !host.programMode;
    assign unitStopped = freeze;

    // ------------------------------------------------------------
    // Per-channel datapath
    // ------------------------------------------------------------
    logic [1:0][15:0] dac_r;
    logic [1:0][15:0] result_r;
    logic [1:0] err_r;
    logic [1:0][15:0] dacNxt;
    logic [1:0][15:0] resultNxt;
    logic [1:0] errNxt;
    logic [1:0] loopOn;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic bip;
            logic loopEn;
            logic loopNeg;
            logic [7:0] holdSel;
            logic signed [31:0] fullV;
            logic signed [31:0] minV;
            logic signed [31:0] maxV;
            logic signed [31:0] ratio;
            logic signed [31:0] bias;
            logic signed [31:0] inCal;
            logic signed [31:0] prod;
            logic signed [31:0] loopVal;
            logic signed [31:0] scLo;
            logic signed [31:0] scHi;
            logic scaleOn;
            logic signed [31:0] setConv;
            logic signed [31:0] target;
            logic signed [31:0] outCal;
            logic signed [31:0] stopLvl;
            logic outErr;
            logic stopOut;

            assign bip = shadow_r[OFF_BASE_SETTING][BIT_RANGE_BIPOLAR0 + ch];
            assign loopEn = shadow_r[OFF_BASE_SETTING][BIT_LOOP1_ENABLE + 2 * ch];
            assign loopNeg = shadow_r[OFF_BASE_SETTING][BIT_LOOP1_NEGATIVE + 2 * ch];
            assign loopOn[ch] = loopEn;
            assign holdSel = shadow_r[OFF_HOLD_OUT1 + 5'(ch)][7:0];
            assign fullV = bip ? FULL_BIP : FULL_UNI;
            assign minV = bip ? MIN_BIP : MIN_UNI;
            assign maxV = bip ? MAX_BIP : MAX_UNI;
            assign ratio = bcdToBin(shadow_r[OFF_LOOP1_RATIO_CONSTANT + 5'(2 * ch)]);
            assign bias = sx(shadow_r[OFF_LOOP1_BIAS_CONSTANT + 5'(2 * ch)]);

            // Input calibration; equal points mean no calibration stored
            always_comb begin
                if (cal.inGain[ch] == cal.inOffset[ch]) begin
                    inCal = sx(adc.rawIn[ch]);
                end else begin
                    inCal = ((sx(adc.rawIn[ch]) - sx(cal.inOffset[ch])) * fullV)
                        / (sx(cal.inGain[ch]) - sx(cal.inOffset[ch]));
                end
            end

            // Truncating divide keeps the product in whole output counts
            assign prod = (ratio * inCal) / RATIO_DIVISOR;
            always_comb begin
                if (loopNeg) begin
                    loopVal = sat(fullV - prod + bias, minV, maxV);
                end else begin
                    loopVal = sat(prod + bias, minV, maxV);
                end
            end

            // Scaling, valid only with sane limits and no ratio loop
            assign scLo = sx(shadow_r[OFF_SCALE_LO_OUT1 + 5'(2 * ch)]);
            assign scHi = sx(shadow_r[OFF_SCALE_HI_OUT1 + 5'(2 * ch)]);
            assign scaleOn = !loopEn && (scLo != scHi) && (scLo >= -SCALE_LIMIT)
                && (scLo <= SCALE_LIMIT) && (scHi >= -SCALE_LIMIT)
                && (scHi <= SCALE_LIMIT);
            // Signed span makes reverse limits invert the mapping
            assign setConv = scaleOn
                ? ((sx(host.setValue[ch]) - scLo) * fullV) / (scHi - scLo)
                : sx(host.setValue[ch]);

            assign outErr = !loopEn && host.convEnable[ch]
                && ((setConv < minV) || (setConv > maxV));
            assign target = loopEn ? loopVal : setConv;

            // Output calibration maps 0000 and full scale onto stored set values
            always_comb begin
                if (cal.outGain[ch] == cal.outOffset[ch]) begin
                    outCal = target;
                end else begin
                    outCal = sx(cal.outOffset[ch]) + (target
                        * (sx(cal.outGain[ch]) - sx(cal.outOffset[ch]))) / fullV;
                end
            end

            always_comb begin
                case (holdSel)
                    HOLD_RANGE_MIN: stopLvl = minV;
                    HOLD_LAST: stopLvl = sx(dac_r[ch]);
                    HOLD_RANGE_MAX: stopLvl = maxV;
                    default: stopLvl = minV;
                endcase
            end

            assign stopOut = !host.convEnable[ch] || outErr
                || (loopEn && adc.disconnected[ch]);
            assign dacNxt[ch] = stopOut ? stopLvl[15:0] : outCal[15:0];
            assign resultNxt[ch] = !loopEn ? 16'h0000
                : (adc.disconnected[ch] ? DISCONNECT_VALUE : loopVal[15:0]);
            assign errNxt[ch] = outErr;
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dac_r <= '0;
            result_r <= '0;
        end else if (!freeze && !loadPending_r) begin
            dac_r <= dacNxt;
            result_r <= resultNxt;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            err_r <= '0;
        end else if (!freeze) begin
            err_r <= errNxt;
        end
    end

    assign dacCode = dac_r;
    assign loop1Result = result_r[0];
    assign loop2Result = result_r[1];
    assign setErrorWord = {14'h0000, err_r[1], err_r[BIT_SET_ERR_OUT1]};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_err_follows;
        @(posedge clock) disable iff (reset)
        !freeze |=> (setErrorWord[1:0] == $past(errNxt));
    endproperty
    a_err_follows: assert property (p_err_follows) else $error("error bits lag");

    property p_err_clears;
        @(posedge clock) disable iff (reset)
        (err_r[0] && !errNxt[0] && !freeze) |=> !setErrorWord[0];
    endproperty
    a_err_clears: assert property (p_err_clears) else $error("error bit stuck");

    property p_err_stop;
        @(posedge clock) disable iff (reset)
        (errNxt[0] && !freeze && !loadPending_r && shadow_r[OFF_HOLD_OUT1][7:0] == HOLD_RANGE_MAX)
        |=> (sx(dacCode[0]) == (shadow_r[OFF_BASE_SETTING][0] ? MAX_BIP : MAX_UNI));
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("error output level wrong");

    property p_disc_zero;
        @(posedge clock) disable iff (reset)
        (loopOn[1] && adc.disconnected[1] && !freeze && !loadPending_r)
        |=> (loop2Result == DISCONNECT_VALUE);
    endproperty
    a_disc_zero: assert property (p_disc_zero) else $error("disconnect result not zero");

    property p_sat;
        @(posedge clock) disable iff (reset)
        1'b1 |-> (sx(loop1Result) <= MAX_UNI) && (sx(loop1Result) >= MIN_BIP);
    endproperty
    a_sat: assert property (p_sat) else $error("loop result not saturated");

    property p_freeze_hold;
        @(posedge clock) disable iff (reset)
        freeze |=> $stable(dacCode) && $stable(loop1Result) && $stable(setErrorWord);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("moved while stopped");

    property p_load_only_restart;
        @(posedge clock) disable iff (reset)
        !loadPending_r |=> $stable(shadow_r);
    endproperty
    a_load_only_restart: assert property (p_load_only_restart) else $error("shadow moved");

    property p_latency;
        @(posedge clock) disable iff (reset)
        (!freeze && !loadPending_r) |=> (dacCode == $past(dacNxt))
            && (result_r == $past(resultNxt));
    endproperty
    a_latency: assert property (p_latency) else $error("output too slow");

    property p_hold_last;
        @(posedge clock) disable iff (reset)
        (!host.convEnable[1] && shadow_r[OFF_HOLD_OUT2][7:0] == HOLD_LAST && !loadPending_r)
        |=> $stable(dacCode[1]);
    endproperty
    a_hold_last: assert property (p_hold_last) else $error("hold last not kept");

    // ------------------------------------------------------------
    // Status word and stop-level checks
    // ------------------------------------------------------------
    property p_err_upper_zero;
        @(posedge clock) disable iff (reset)
        1'b1 |-> (setErrorWord[15:2] == 14'h0000);
    endproperty
    a_err_upper_zero: assert property (p_err_upper_zero) else $error("spare bits set");

    property p_err_out2;
        @(posedge clock) disable iff (reset)
        (!freeze && host.convEnable[1] && !loopOn[1] && !shadow_r[OFF_BASE_SETTING][1]
            && (shadow_r[OFF_SCALE_LO_OUT2] == 16'h0000)
            && (shadow_r[OFF_SCALE_HI_OUT2] == 16'h0000)
            && (sx(host.setValue[1]) > MAX_UNI)) |=> setErrorWord[1];
    endproperty
    a_err_out2: assert property (p_err_out2) else $error("output 2 error missing");

    property p_disc_stop;
        @(posedge clock) disable iff (reset)
        (loopOn[0] && adc.disconnected[0] && !freeze && !loadPending_r
            && shadow_r[OFF_HOLD_OUT1][7:0] == HOLD_RANGE_MAX)
        |=> (sx(dacCode[0]) == (shadow_r[OFF_BASE_SETTING][0] ? MAX_BIP : MAX_UNI));
    endproperty
    a_disc_stop: assert property (p_disc_stop) else $error("disconnect level wrong");

    property p_stop_min;
        @(posedge clock) disable iff (reset)
        (!host.convEnable[0] && !freeze && !loadPending_r
            && shadow_r[OFF_HOLD_OUT1][7:0] == HOLD_RANGE_MIN)
        |=> (sx(dacCode[0]) == (shadow_r[OFF_BASE_SETTING][0] ? MIN_BIP : MIN_UNI));
    endproperty
    a_stop_min: assert property (p_stop_min) else $error("stop minimum wrong");

    property p_result_off;
        @(posedge clock) disable iff (reset)
        (!loopOn[1] && !freeze && !loadPending_r) |=> (loop2Result == 16'h0000);
    endproperty
    a_result_off: assert property (p_result_off) else $error("idle loop result set");

    property p_loop_no_err;
        @(posedge clock) disable iff (reset)
        (loopOn[0] && !freeze) |=> !setErrorWord[0];
    endproperty
    a_loop_no_err: assert property (p_loop_no_err) else $error("scaling error under loop");

    property p_sat2;
        @(posedge clock) disable iff (reset)
        1'b1 |-> (sx(loop2Result) <= MAX_UNI) && (sx(loop2Result) >= MIN_BIP);
    endproperty
    a_sat2: assert property (p_sat2) else $error("loop 2 result not saturated");

    c_error: cover property (@(posedge clock) disable iff (reset) $rose(setErrorWord[0]));
    c_loop: cover property (@(posedge clock) disable iff (reset)
        loopOn[0] && !adc.disconnected[0] && !freeze ##1 loop1Result != 16'h0000);
    c_restart: cover property (@(posedge clock) disable iff (reset) $rose(host.restartReq));
    c_freeze: cover property (@(posedge clock) disable iff (reset) $rose(unitStopped));
    c_calib: cover property (@(posedge clock) disable iff (reset)
        loopOn[0] && (cal.inGain[0] != cal.inOffset[0]) && (cal.outGain[0] != cal.outOffset[0]));
endmodule : aru_ratio_unit

// *** tb/aru_host_model.sv ***
// Controller-side model: setting memory area and unit restart bit
`timescale 1ns/10ps
module aru_host_model (
    // Clock
    input wire logic clock,
    // Words toward the unit
    output aru_pkg::aru_settings_t settingArea,
    output logic restartReq
);
    import aru_pkg::*;
    initial begin
        settingArea = '0;
        restartReq = 1'b0;
    end
    task automatic setWord(input logic [4:0] idx, input aru_word_t val);
        settingArea[idx] = val;
    endtask : setWord
    // Edits stay invisible to the unit until this pulse is sent
    task automatic restart();
        @(posedge clock);
        #1 restartReq = 1'b1;
        @(posedge clock);
        #1 restartReq = 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : restart
endmodule : aru_host_model

// *** tb/test_analog_ratio_conversion_unit.sv ***
// Self-checking bench of the ratio conversion unit
`timescale 1ns/10ps
module test_analog_ratio_conversion_unit;
    import aru_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    aru_settings_t settingArea;
    aru_host_t host;
    aru_adc_t adc;
    aru_cal_t cal = '0;
    logic restartReq;
    logic [1:0][15:0] setValue = '0;
    logic [1:0] convEnable = 2'b11;
    logic adjustMode = 1'b0;
    logic programMode = 1'b1;
    logic [1:0][15:0] rawIn = '0;
    logic [1:0] disconnected = 2'b00;
    logic [1:0][15:0] dacCode;
    logic [15:0] loop1Result, loop2Result, setErrorWord;
    logic unitStopped;
    int failCount = 0;
    int checks = 0;
    assign host = {setValue, convEnable, restartReq, adjustMode, programMode};
    assign adc = {rawIn, disconnected};
    always #2 clock = ~clock;
    aru_host_model i_host (.clock(clock), .settingArea(settingArea), .restartReq(restartReq));
    aru_ratio_unit i_dut (.clock(clock), .reset(reset), .settingArea(settingArea),
        .host(host), .adc(adc), .cal(cal), .dacCode(dacCode), .loop1Result(loop1Result),
        .loop2Result(loop2Result), .setErrorWord(setErrorWord), .unitStopped(unitStopped));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic endSim();
        $display("checks=%0d failCount=%0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : endSim
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            failCount++;
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_loop_pos();
        i_host.setWord(OFF_BASE_SETTING, 16'h0100);
        i_host.setWord(OFF_LOOP1_RATIO_CONSTANT, 16'h0125);
        i_host.setWord(OFF_LOOP1_BIAS_CONSTANT, 16'h0190);
        i_host.setWord(OFF_HOLD_OUT1, 16'h0002);
        i_host.restart();
        rawIn[0] = 16'h03E8;
        step(2);
        chk("loop1Result", 16'h0672, loop1Result);
        chk("dacCode0", 16'h0672, dacCode[0]);
        rawIn[0] = 16'h0007;
        step(2);
        chk("loop1Result", 16'h0198, loop1Result);
        rawIn[0] = 16'h0FA0;
        step(2);
        chk("loop1Result", 16'h1068, loop1Result);
        disconnected[0] = 1'b1;
        step(2);
        chk("loop1Result", 16'h0000, loop1Result);
        chk("dacCode0", 16'h1068, dacCode[0]);
        disconnected[0] = 1'b0;
    endtask : t_loop_pos
    task automatic t_loop_neg();
        i_host.setWord(OFF_BASE_SETTING, 16'h0C00);
        i_host.setWord(OFF_LOOP2_RATIO_CONSTANT, 16'h1000);
        i_host.setWord(OFF_LOOP2_BIAS_CONSTANT, 16'hFF9C);
        i_host.restart();
        rawIn[1] = 16'h0064;
        step(2);
        chk("loop2Result", 16'h0B54, loop2Result);
        chk("dacCode1", 16'h0B54, dacCode[1]);
        chk("loop1Result", 16'h0000, loop1Result);
        rawIn[1] = 16'h03E8;
        step(2);
        chk("loop2Result", 16'hFF38, loop2Result);
        chk("dacCode1", 16'hFF38, dacCode[1]);
    endtask : t_loop_neg
    task automatic t_set_error();
        i_host.setWord(OFF_BASE_SETTING, 16'h0000);
        i_host.setWord(OFF_HOLD_OUT1, 16'h0101);
        i_host.setWord(OFF_HOLD_OUT2, 16'h0002);
        i_host.restart();
        setValue = {16'h0000, 16'h0800};
        step(2);
        chk("setErrorWord", 16'h0000, setErrorWord);
        chk("dacCode0", 16'h0800, dacCode[0]);
        setValue = {16'h1069, 16'hFF37};
        step(2);
        chk("setErrorWord", 16'h0003, setErrorWord);
        chk("dacCode0", 16'h0800, dacCode[0]);
        chk("dacCode1", 16'h1068, dacCode[1]);
        setValue = {16'hFF38, 16'h1068};
        step(2);
        chk("setErrorWord", 16'h0000, setErrorWord);
        chk("dacCode0", 16'h1068, dacCode[0]);
        chk("dacCode1", 16'hFF38, dacCode[1]);
    endtask : t_set_error
    task automatic t_scaling();
        logic [15:0] sv [5] = '{16'h2710, 16'h0000, 16'h2904, 16'hFE0C, 16'hD8F0};
        logic [15:0] ex [5] = '{16'h0000, 16'h0FA0, 16'hFF38, 16'h1068, 16'hFF38};
        i_host.setWord(OFF_HOLD_OUT1, 16'h0000);
        i_host.setWord(OFF_SCALE_LO_OUT1, 16'h2710);
        i_host.setWord(OFF_SCALE_HI_OUT1, 16'h0000);
        i_host.restart();
        for (int i = 0; i < 5; i++) begin
            setValue[0] = sv[i];
            step(2);
            chk("dacCode0", ex[i], dacCode[0]);
            chk("setErrorWord", (i == 4) ? 16'h0001 : 16'h0000, setErrorWord);
        end
    endtask : t_scaling
    task automatic t_restart();
        i_host.setWord(OFF_SCALE_LO_OUT1, 16'h0000);
        setValue[0] = 16'h0000;
        step(3);
        chk("dacCode0", 16'h0FA0, dacCode[0]);
        i_host.restart();
        chk("dacCode0", 16'h0000, dacCode[0]);
    endtask : t_restart
    task automatic t_stop();
        setValue[0] = 16'h0100;
        step(2);
        adjustMode = 1'b1;
        programMode = 1'b0;
        step(1);
        chk("unitStopped", 16'h0001, {15'h0000, unitStopped});
        setValue[0] = 16'h0200;
        step(3);
        chk("dacCode0", 16'h0100, dacCode[0]);
        programMode = 1'b1;
        step(2);
        chk("unitStopped", 16'h0000, {15'h0000, unitStopped});
        chk("dacCode0", 16'h0200, dacCode[0]);
        adjustMode = 1'b0;
    endtask : t_stop
    task automatic t_calib();
        i_host.setWord(OFF_BASE_SETTING, 16'h0100);
        i_host.setWord(OFF_LOOP1_RATIO_CONSTANT, 16'h0100);
        i_host.setWord(OFF_LOOP1_BIAS_CONSTANT, 16'h0000);
        i_host.setWord(OFF_SCALE_LO_OUT1, 16'h2710);
        i_host.setWord(OFF_HOLD_OUT2, 16'h0001);
        cal.inOffset[0] = 16'hFF38;
        cal.inGain[0] = 16'h0EDA;
        cal.outOffset[0] = 16'hFFFB;
        cal.outGain[0] = 16'h0F9B;
        setValue[1] = 16'h0123;
        rawIn[0] = 16'hFF38;
        i_host.restart();
        chk("loop1Result", 16'h0000, loop1Result);
        chk("dacCode0", 16'hFFFB, dacCode[0]);
        rawIn[0] = 16'h0EDA;
        step(2);
        chk("loop1Result", 16'h0FA0, loop1Result);
        chk("dacCode0", 16'h0F9B, dacCode[0]);
        chk("dacCode1", 16'h0123, dacCode[1]);
        convEnable = 2'b00;
        step(2);
        chk("dacCode0", 16'hFF38, dacCode[0]);
        chk("dacCode1", 16'h0123, dacCode[1]);
        chk("setErrorWord", 16'h0000, setErrorWord);
        chk("loop1Result", 16'h0FA0, loop1Result);
    endtask : t_calib
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        #1 reset = 1'b0;
        step(2);
        t_loop_pos();
        t_loop_neg();
        t_set_error();
        t_scaling();
        t_restart();
        t_stop();
        t_calib();
        endSim();
    end
    // Whole run is under a hundred cycles; this leaves a wide margin
    initial begin
        #40000;
        $display("unexpected watchdog expected 0 seen 1");
        failCount++;
        endSim();
    end
endmodule : test_analog_ratio_conversion_unit
